// file: logic/pmrd_cfg.svh
/*
 * constants of the program memory read port: register indices, field positions,
 * reset values, widths, bus response codes and the read sequence length.
 * assumes it is included by bare name from the package and the design modules.
 */
// Functional notes
// [RULE1] word returned in low and high data bytes
// [RULE2] read address is high byte plus low byte
// [RULE3] unused high bits not stored, read zero
// [RULE4] software keeps unused address high bits clear
// [RULE5] go bit starts read, hardware clears it
// [RULE6] writing zero to go bit does nothing
// [RULE7] software writes address before setting go
// [RULE8] read takes the next two instruction cycles
// [RULE9] first cycle after go runs normally
// [RULE10] second cycle after go is ignored
// [RULE11] word held in data registers until next read
// [RULE12] no or full protection: any address readable
// [RULE13] partial protection: protected segment reads refused
// [RULE14] control bit 7 reads one, bits 6-1 zero
// [RULE15] address range covers at most 8K words
// [RULE16] refused read still clears go on time
`ifndef PMRD_CFG_SVH
`define PMRD_CFG_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PMRD_IDX_W          10
`define PMRD_IDX_CTRL       10'h10c
`define PMRD_IDX_DATA_LO    10'h18c
`define PMRD_IDX_ADDR_LO    10'h18d
`define PMRD_IDX_DATA_HI    10'h18e
`define PMRD_IDX_ADDR_HI    10'h18f

// ****************************************************************
// field layout and reset values
// ****************************************************************
`define PMRD_WORD_W         14
`define PMRD_ADDR_W         13
`define PMRD_BYTE_W         8
`define PMRD_DATA_HI_W      6
`define PMRD_ADDR_HI_W      5
`define PMRD_CTRL_GO_BIT    0
`define PMRD_CTRL_RSV_BIT   7
`define PMRD_CTRL_RSV_VAL   1'b1
`define PMRD_DATA_LO_RST    8'h00
`define PMRD_DATA_HI_RST    6'h00
`define PMRD_ADDR_LO_RST    8'h00
`define PMRD_ADDR_HI_RST    5'h00

// ****************************************************************
// bus and sequence
// ****************************************************************
`define PMRD_AXI_AW         12
`define PMRD_AXI_DW         32
`define PMRD_RESP_OKAY      2'h0
`define PMRD_RESP_SLVERR    2'h2
`define PMRD_READ_CYCLES    2

`endif

// file: logic/pmrd_pkg.sv
/*
 * types of the program memory read port: sequencer states, protection modes,
 * memory request and internal register write request.
 * assumes pmrd_cfg.svh is on the include path.
 */
`include "pmrd_cfg.svh"

package pmrd_pkg;

	typedef enum logic [1:0] {
		PMRD_IDLE  = 2'b00,
		PMRD_SLOT1 = 2'b01,
		PMRD_SLOT2 = 2'b10
	} pmrd_state_t;

	typedef enum logic [1:0] {
		PMRD_CP_NONE = 2'b00,
		PMRD_CP_ALL  = 2'b01,
		PMRD_CP_PART = 2'b10
	} pmrd_cp_t;

	typedef struct packed {
		logic                    en;
		logic [`PMRD_ADDR_W-1:0] addr;
	} pmrd_mem_req_t;

	typedef struct packed {
		logic                    fire;
		logic [`PMRD_IDX_W-1:0]  idx;
		logic [`PMRD_BYTE_W-1:0] data;
		logic                    lane0;
	} pmrd_wreq_t;

endpackage

// file: logic/pmrd_field.sv
/*
 * one W-bit register field (a byte by default) with a software write port and a hardware load
 * port; the hardware load wins when both act in one cycle.
 * assumes a synchronous active-low reset on aclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmrd_cfg.svh"

module pmrd_field #(
	parameter int unsigned W           = `PMRD_BYTE_W,
	parameter logic [W-1:0] RESET_VAL  = '0
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// software side
	input  wire logic         sw_we,
	input  wire logic [W-1:0] sw_d,
	// hardware side
	input  wire logic         hw_we,
	input  wire logic [W-1:0] hw_d,
	// stored value
	output logic      [W-1:0] q
);
	import pmrd_pkg::*;

	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	// only W bits are kept, so the unused top of a byte cannot hold anything
	assign q_next = hw_we ? hw_d : (sw_we ? sw_d : q_reg); // [RULE3]
	assign q      = q_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_reg <= RESET_VAL;
		end else begin
			q_reg <= q_next;
		end
	end
endmodule // pmrd_field
`default_nettype wire

// file: logic/pmrd_seq.sv
/*
 * read sequencer: after a start it spends one normal slot, then one slot in
 * which program memory is read, and reports the finished word.
 * assumes program memory answers combinationally within the access slot.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmrd_cfg.svh"

module pmrd_seq (
	// clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// start from the control register
	input  wire logic                      start,
	input  wire logic [`PMRD_ADDR_W-1:0]   start_addr,
	// code protection fuses
	input  wire pmrd_pkg::pmrd_cp_t        cp_mode,
	input  wire logic [`PMRD_ADDR_W-1:0]   cp_bound,
	// program memory
	output pmrd_pkg::pmrd_mem_req_t        mem_req,
	input  wire logic [`PMRD_WORD_W-1:0]   mem_rdata,
	// status
	output pmrd_pkg::pmrd_state_t          state,
	output logic                           done,
	output logic [`PMRD_WORD_W-1:0]        done_data
);
	import pmrd_pkg::*;

	pmrd_state_t             state_reg;
	pmrd_state_t             state_next;
	logic [`PMRD_ADDR_W-1:0] addr_reg;
	logic                    en_reg;
	logic                    allowed;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PMRD_IDLE:  if (start) state_next = PMRD_SLOT1; // [RULE8]
			PMRD_SLOT1: state_next = PMRD_SLOT2;           // [RULE9]
			PMRD_SLOT2: state_next = PMRD_IDLE;            // [RULE10]
			default:    state_next = PMRD_IDLE;
		endcase
	end

	// address is frozen at start so a late write cannot bend the fetch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= PMRD_IDLE;
			addr_reg  <= '0;
			en_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == PMRD_IDLE && start) addr_reg <= start_addr; // [RULE2] [RULE15]
			en_reg    <= (state_next == PMRD_SLOT2);
		end
	end

	// partial protection: everything at or above the bound is the protected segment
	assign allowed   = (cp_mode != PMRD_CP_PART) || (addr_reg < cp_bound); // [RULE12] [RULE13]
	assign done      = (state_reg == PMRD_SLOT2); // [RULE16]
	assign done_data = allowed ? mem_rdata : '0;  // [RULE13]
	assign mem_req   = '{en: en_reg, addr: addr_reg};
	assign state     = state_reg;
endmodule // pmrd_seq
`default_nettype wire

// file: logic/pmrd_top.sv
/*
 * program memory read port: AXI4-Lite register slave holding control, address
 * and data bytes, plus the two-slot read sequence into program memory.
 * assumes program memory data is combinational from the request address on
 * aclk, and code protection inputs are static fuse levels on aclk.
 */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pmrd_cfg.svh"

module pmrd_top (
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite write address
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [`PMRD_AXI_AW-1:0]     s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	// axi4-lite write data
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	input  wire logic [`PMRD_AXI_DW-1:0]     s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	// axi4-lite write response
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output logic [1:0]                       s_axi_bresp,
	// axi4-lite read address
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	input  wire logic [`PMRD_AXI_AW-1:0]     s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	// axi4-lite read data
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [`PMRD_AXI_DW-1:0]          s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	// program memory
	output pmrd_pkg::pmrd_mem_req_t          mem_req,
	input  wire logic [`PMRD_WORD_W-1:0]     mem_rdata,
	// code protection fuses
	input  wire pmrd_pkg::pmrd_cp_t          cp_mode,
	input  wire logic [`PMRD_ADDR_W-1:0]     cp_bound
);
	import pmrd_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic                      awready_reg;
	logic                      wready_reg;
	logic                      bvalid_reg;
	logic [1:0]                bresp_reg;
	logic                      arready_reg;
	logic                      rvalid_reg;
	logic [`PMRD_AXI_DW-1:0]   rdata_reg;
	logic [1:0]                rresp_reg;
	logic                      go_reg;
	logic                      go_next;

	pmrd_wreq_t                wreq;
	logic                      wr_take;
	logic                      rd_take;
	logic                      wr_fire;
	logic                      rd_fire;
	logic                      bus_stall;
	logic [`PMRD_IDX_W-1:0]    rd_idx;

	logic                      wsel_ctrl;
	logic                      wsel_data_lo;
	logic                      wsel_data_hi;
	logic                      wsel_addr_lo;
	logic                      wsel_addr_hi;
	logic                      wr_mapped;
	logic                      rd_mapped;
	logic                      go_set;

	logic [`PMRD_BYTE_W-1:0]    data_lo_q;
	logic [`PMRD_DATA_HI_W-1:0] data_hi_q;
	logic [`PMRD_BYTE_W-1:0]    addr_lo_q;
	logic [`PMRD_ADDR_HI_W-1:0] addr_hi_q;
	logic [`PMRD_BYTE_W-1:0]    ctrl_view;
	logic [`PMRD_BYTE_W-1:0]    rd_byte;

	pmrd_state_t               seq_state;
	logic                      seq_done;
	logic [`PMRD_WORD_W-1:0]   seq_data;

	// ****************************************************************
	// bus handshake
	// ****************************************************************
	// no handshake may land in the access slot, so readiness is never raised
	// in the slot before it; that slot's request simply waits a cycle
	assign bus_stall = (seq_state == PMRD_SLOT1); // [RULE10]

	// write address and data are taken together, one write at a time
	assign wr_take = s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg && !bus_stall;
	assign wr_fire = awready_reg && s_axi_awvalid && wready_reg && s_axi_wvalid;
	assign rd_take = s_axi_arvalid && !arready_reg && !rvalid_reg && !bus_stall;
	assign rd_fire = arready_reg && s_axi_arvalid;

	assign wreq = '{fire:  wr_fire,
	                idx:   s_axi_awaddr[`PMRD_IDX_W+1:2],
	                data:  s_axi_wdata[`PMRD_BYTE_W-1:0],
	                lane0: s_axi_wstrb[0]};
	assign rd_idx = s_axi_araddr[`PMRD_IDX_W+1:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
		end else begin
			awready_reg <= wr_take;
			wready_reg  <= wr_take;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `PMRD_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? `PMRD_RESP_OKAY : `PMRD_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
		end else begin
			arready_reg <= rd_take;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= `PMRD_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= {{(`PMRD_AXI_DW-`PMRD_BYTE_W){1'b0}}, rd_byte};
			rresp_reg  <= rd_mapped ? `PMRD_RESP_OKAY : `PMRD_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// write decode
	// ****************************************************************
	// only byte lane 0 carries register bits; other lanes are accepted and dropped
	assign wsel_ctrl    = wreq.fire && wreq.lane0 && (wreq.idx == `PMRD_IDX_CTRL);
	assign wsel_data_lo = wreq.fire && wreq.lane0 && (wreq.idx == `PMRD_IDX_DATA_LO);
	assign wsel_data_hi = wreq.fire && wreq.lane0 && (wreq.idx == `PMRD_IDX_DATA_HI);
	assign wsel_addr_lo = wreq.fire && wreq.lane0 && (wreq.idx == `PMRD_IDX_ADDR_LO);
	assign wsel_addr_hi = wreq.fire && wreq.lane0 && (wreq.idx == `PMRD_IDX_ADDR_HI);
	assign wr_mapped    = (wreq.idx == `PMRD_IDX_CTRL)    || (wreq.idx == `PMRD_IDX_DATA_LO) ||
	                      (wreq.idx == `PMRD_IDX_DATA_HI) || (wreq.idx == `PMRD_IDX_ADDR_LO) ||
	                      (wreq.idx == `PMRD_IDX_ADDR_HI);

	// ****************************************************************
	// control register
	// ****************************************************************
	// a one starts a read only while idle; a zero is simply ignored
	assign go_set  = wsel_ctrl && wreq.data[`PMRD_CTRL_GO_BIT] && !go_reg; // [RULE5] [RULE6]
	// completion and a new set can never meet: a set needs the go bit low
	assign go_next = seq_done ? 1'b0 : (go_set ? 1'b1 : go_reg); // [RULE5] [RULE16]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			go_reg <= 1'b0;
		end else begin
			go_reg <= go_next;
		end
	end

	assign ctrl_view = {`PMRD_CTRL_RSV_VAL, 6'h00, go_reg}; // [RULE14]

	// ****************************************************************
	// address and data bytes
	// ****************************************************************
	pmrd_field #(
		.W         (`PMRD_BYTE_W),
		.RESET_VAL (`PMRD_ADDR_LO_RST)
	) u_addr_lo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sw_we   (wsel_addr_lo),
		.sw_d    (wreq.data),
		.hw_we   (1'b0),
		.hw_d    (`PMRD_ADDR_LO_RST),
		.q       (addr_lo_q)
	);

	// upper address bits beyond the 8K range are not stored at all
	pmrd_field #(
		.W         (`PMRD_ADDR_HI_W),
		.RESET_VAL (`PMRD_ADDR_HI_RST)
	) u_addr_hi (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sw_we   (wsel_addr_hi),
		.sw_d    (wreq.data[`PMRD_ADDR_HI_W-1:0]), // [RULE3] [RULE4] [RULE15]
		.hw_we   (1'b0),
		.hw_d    (`PMRD_ADDR_HI_RST),
		.q       (addr_hi_q)
	);

	// finished word lands here at the end of the access slot and stays
	pmrd_field #(
		.W         (`PMRD_BYTE_W),
		.RESET_VAL (`PMRD_DATA_LO_RST)
	) u_data_lo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sw_we   (wsel_data_lo),
		.sw_d    (wreq.data),
		.hw_we   (seq_done),                         // [RULE11]
		.hw_d    (seq_data[`PMRD_BYTE_W-1:0]),       // [RULE1]
		.q       (data_lo_q)
	);

	pmrd_field #(
		.W         (`PMRD_DATA_HI_W),
		.RESET_VAL (`PMRD_DATA_HI_RST)
	) u_data_hi (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sw_we   (wsel_data_hi),
		.sw_d    (wreq.data[`PMRD_DATA_HI_W-1:0]),   // [RULE3]
		.hw_we   (seq_done),                         // [RULE11]
		.hw_d    (seq_data[`PMRD_WORD_W-1:`PMRD_BYTE_W]), // [RULE1]
		.q       (data_hi_q)
	);

	// ****************************************************************
	// read sequence
	// ****************************************************************
	// the address is taken from both bytes as they stand when go is set
	pmrd_seq u_seq (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.start      (go_set),                   // [RULE7] [RULE8]
		.start_addr ({addr_hi_q, addr_lo_q}),   // [RULE2]
		.cp_mode    (cp_mode),
		.cp_bound   (cp_bound),
		.mem_req    (mem_req),
		.mem_rdata  (mem_rdata),
		.state      (seq_state),
		.done       (seq_done),
		.done_data  (seq_data)
	);

	// ****************************************************************
	// read mux
	// ****************************************************************
	assign rd_mapped = (rd_idx == `PMRD_IDX_CTRL)    || (rd_idx == `PMRD_IDX_DATA_LO) ||
	                   (rd_idx == `PMRD_IDX_DATA_HI) || (rd_idx == `PMRD_IDX_ADDR_LO) ||
	                   (rd_idx == `PMRD_IDX_ADDR_HI);

	// unused high bits read back as zero
	assign rd_byte = (rd_idx == `PMRD_IDX_CTRL)    ? ctrl_view :
	                 (rd_idx == `PMRD_IDX_DATA_LO) ? data_lo_q :
	                 (rd_idx == `PMRD_IDX_DATA_HI) ? {2'h0, data_hi_q} : // [RULE3]
	                 (rd_idx == `PMRD_IDX_ADDR_LO) ? addr_lo_q :
	                 (rd_idx == `PMRD_IDX_ADDR_HI) ? {3'h0, addr_hi_q} : // [RULE3]
	                 8'h00;

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
endmodule // pmrd_top
`default_nettype wire

// file: test/pmrd_top_asserts.sv
/*
 * checker of the program memory read port, bound into pmrd_top.
 * assumes pmrd_cfg.svh on the include path and pmrd_pkg compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmrd_cfg.svh"

module pmrd_chk (
	// clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// register bus
	input  wire logic                      s_axi_awvalid,
	input  wire logic                      s_axi_awready,
	input  wire logic [`PMRD_AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                      s_axi_wvalid,
	input  wire logic                      s_axi_wready,
	input  wire logic [`PMRD_AXI_DW-1:0]   s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [1:0]                s_axi_bresp,
	input  wire logic                      s_axi_arvalid,
	input  wire logic                      s_axi_arready,
	input  wire logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic [`PMRD_AXI_DW-1:0]   s_axi_rdata,
	input  wire logic [1:0]                s_axi_rresp,
	// program memory
	input  wire pmrd_pkg::pmrd_mem_req_t   mem_req
);
	import pmrd_pkg::*;

	// ********************************
	// helper
	// ********************************
	wire logic go_wr;
	assign go_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wstrb[0] && s_axi_wdata[0]
		&& (s_axi_awaddr == {`PMRD_IDX_CTRL, 2'b00});

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ********************************
	// properties
	// ********************************
	a_go_slots: assert property (go_wr |=> !mem_req.en ##1 mem_req.en)
		else $error("access slot not second cycle after go");
	a_slot_cause: assert property (mem_req.en |-> $past(go_wr, 2))
		else $error("access slot without go");
	a_slot_single: assert property (mem_req.en |=> !mem_req.en)
		else $error("access slot longer than one cycle");
	a_slot_quiet: assert property (mem_req.en |-> !s_axi_awready && !s_axi_arready)
		else $error("bus handshake in access slot");
	a_hi_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == `PMRD_RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read with data");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	a_w_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("write address and data ready apart");
endmodule // pmrd_chk

bind pmrd_top pmrd_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mem_req);

`default_nettype wire

// file: test/pmrd_top_test.sv
/*
 * self-checking bench of the program memory read port over AXI4-Lite.
 * assumes pmrd_pkg and the design compiled first; memory is modelled here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmrd_cfg.svh"

module pmrd_top_test;
	import pmrd_pkg::*;

	// ********************************
	// signals
	// ********************************
	localparam logic [11:0] A_CTRL = {`PMRD_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_DLO  = {`PMRD_IDX_DATA_LO, 2'b00};
	localparam logic [11:0] A_ALO  = {`PMRD_IDX_ADDR_LO, 2'b00};
	localparam logic [11:0] A_DHI  = {`PMRD_IDX_DATA_HI, 2'b00};
	localparam logic [11:0] A_AHI  = {`PMRD_IDX_ADDR_HI, 2'b00};
	localparam logic [1:0]  OK     = `PMRD_RESP_OKAY;
	localparam logic [1:0]  ERR    = `PMRD_RESP_SLVERR;
	logic          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]   s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]    s_axi_wstrb;
	logic [1:0]    s_axi_bresp, s_axi_rresp, rr;
	logic [13:0]   mem_rdata, key;
	logic [12:0]   cp_bound;
	pmrd_mem_req_t mem_req;
	pmrd_cp_t      cp_mode;
	int            err_total, n_checks, seed, a, m, k, bnd, exp_w;

	// word stored at an address: a scramble keyed at random
	assign mem_rdata = {mem_req.addr[7:0], mem_req.addr[12:7]} ^ key;

	pmrd_top dut_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .mem_req, .mem_rdata, .cp_mode, .cp_bound);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ********************************
	// tasks
	// ********************************
	function automatic int mexp(int ad);
		return (((ad & 255) << 6) | (ad >> 7)) ^ int'(key);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ready sampled mid-cycle, valid released on the edge that takes it
	task automatic wr(input logic [11:0] adr, input logic [7:0] d, input logic st, input logic [1:0] er);
		logic h;
		@(posedge aclk);
		s_axi_awaddr  <= adr;
		s_axi_wdata   <= {24'h0, d};
		s_axi_wstrb   <= {3'h7, st};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(negedge aclk);
			h = s_axi_awready;
			@(posedge aclk);
		end while (!h);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		s_axi_awaddr  <= ~adr;
		s_axi_wdata   <= ~{24'h0, d};
		do begin
			@(negedge aclk);
			h = s_axi_bvalid;
			rr = s_axi_bresp;
			@(posedge aclk);
		end while (!h);
		s_axi_bready <= 1'b0;
		chk({30'h0, rr}, {30'h0, er});
	endtask

	task automatic rdchk(input logic [11:0] adr, input logic [31:0] exp, input logic [1:0] er);
		logic h;
		@(posedge aclk);
		s_axi_araddr  <= adr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(negedge aclk);
			h = s_axi_arready;
			@(posedge aclk);
		end while (!h);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr  <= ~adr;
		do begin
			@(negedge aclk);
			h = s_axi_rvalid;
			rr = s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge aclk);
		end while (!h);
		s_axi_rready <= 1'b0;
		chk(rd, exp);
		chk({30'h0, rr}, {30'h0, er});
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ********************************
	// sequence
	// ********************************
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		give_verdict;
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 12'h0;
		s_axi_araddr = 12'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		seed = 6;
		key = 14'($random(seed));
		cp_mode = PMRD_CP_NONE;
		cp_bound = 13'h0;
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(A_CTRL, 32'h80, OK);
		rdchk(A_DLO, 32'h0, OK);
		rdchk(A_DHI, 32'h0, OK);
		rdchk(A_ALO, 32'h0, OK);
		rdchk(A_AHI, 32'h0, OK);
		rdchk(12'h000, 32'h0, ERR);
		wr(12'h004, 8'hff, 1'b1, ERR);
		wr(A_AHI, 8'hff, 1'b1, OK);
		rdchk(A_AHI, 32'h1f, OK);
		wr(A_DHI, 8'hff, 1'b1, OK);
		rdchk(A_DHI, 32'h3f, OK);
		wr(A_CTRL, 8'hfe, 1'b1, OK);
		rdchk(A_CTRL, 32'h80, OK);
		wr(A_ALO, 8'h5a, 1'b0, OK);
		rdchk(A_ALO, 32'h0, OK);
		wr(A_DLO, 8'h3c, 1'b1, OK);
		rdchk(A_DLO, 32'h3c, OK);
		$display("test registers done");
		for (m = 0; m < 3; m++) begin
			bnd = ($random(seed) & 32'h1fff) | 1;
			cp_mode <= pmrd_cp_t'(m);
			cp_bound <= 13'(bnd);
			for (k = 0; k < 6; k++) begin
				a = $random(seed) & 32'h1fff;
				if (k == 0)
					a = bnd;
				if (k == 1)
					a = bnd - 1;
				if (k == 2)
					a = 32'h1fff;
				exp_w = (m == 2 && a >= bnd) ? 0 : mexp(a);
				wr(A_AHI, 8'(a >> 8), 1'b1, OK);
				wr(A_ALO, 8'(a), 1'b1, OK);
				wr(A_CTRL, {7'($random(seed)), 1'b1}, 1'b1, OK);
				rdchk(A_CTRL, 32'h80, OK);
				rdchk(A_DLO, exp_w & 255, OK);
				rdchk(A_DHI, exp_w >> 8, OK);
				wr(A_ALO, 8'(~a), 1'b1, OK);
				rdchk(A_DLO, exp_w & 255, OK);
			end
			$display("test protection mode %0d done", m);
		end
		// reset lands in the access slot of a running read: nothing may be loaded
		wr(A_CTRL, 8'h01, 1'b1, OK);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(A_CTRL, 32'h80, OK);
		rdchk(A_DLO, 32'h0, OK);
		rdchk(A_AHI, 32'h0, OK);
		$display("test reset done");
		give_verdict;
	end
endmodule // pmrd_top_test

`default_nettype wire
